// ---- dtas_active_set.sv ----
// Notes on behaviour
// (RL1) The source set shows a 16-bit source array stride in its low half.
// (RL2) The upper half of the stride register, the dst stride, reads zero.
// (RL3) On request submission the host privilege level is captured.
// (RL4) Every read and write command carries the captured privilege level.
// (RL5) On request submission the 4-bit host privilege id is captured.
// (RL6) Every read and write command carries the captured privilege id.
// (RL7) The privilege id is one for the DSP core and zero for other hosts.
// (RL8) Source and destination sets each hold a 16-bit first-dim reload.
// (RL9) After each array but the last the working first-dim count reloads.
// (RL10) A 32-bit source base holds the start of the array being read.
// (RL11) The source base of the destination FIFO set always reads zero.
// (RL12) The working first-dim count drops as each read command issues.
// (RL13) Status registers are read-only; writes leave them unchanged.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
module dtas_active_set
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [dtas_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dtas_pkg::DATA_W-1:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [dtas_pkg::DATA_W-1:0] RDATA,
  input wire logic TR_VALID,
  output logic TR_READY,
  input wire logic [dtas_pkg::DATA_W-1:0] TR_SRC_ADDR,
  input wire logic [dtas_pkg::DATA_W-1:0] TR_DST_ADDR,
  input wire logic [dtas_pkg::CNT_W-1:0] TR_FIRST_DIM_BYTE_COUNT,
  input wire logic [dtas_pkg::CNT_W-1:0] TR_BCNT,
  input wire logic [dtas_pkg::CNT_W-1:0] TR_SRC_STRIDE,
  input wire logic [dtas_pkg::CNT_W-1:0] TR_DST_STRIDE,
  input wire logic TR_HOST_PRIVILEGE_LEVEL,
  input wire logic TR_HOST_DSP,
  output logic TR_DONE,
  output logic CMD_VALID,
  input wire logic CMD_READY,
  output logic CMD_WRITE,
  output logic [dtas_pkg::DATA_W-1:0] CMD_ADDR,
  output logic [dtas_pkg::CNT_W-1:0] CMD_BYTES,
  output logic CMD_HOST_PRIVILEGE_LEVEL,
  output logic [dtas_pkg::ID_W-1:0] CMD_HOST_PRIVILEGE_ID
);
  import dtas_pkg::*;

  dtas_state_s s;
  dtas_state_s n;

  // Next array start: base plus unsigned byte stride
  function automatic logic [DATA_W-1:0] step_base(
    input logic [DATA_W-1:0] base,
    input logic [CNT_W-1:0] stride
  );
    step_base = base + {{(DATA_W-CNT_W){1'b0}}, stride};
  endfunction

  // Register read decode
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] a,
    input dtas_state_s st
  );
    logic [DATA_W-1:0] w;
    w = READ_ZERO;
    case (a)
      STRIDE_OFS:
      begin
        w[SRC_STRIDE_LSB +: CNT_W] = st.src_stride; // RL1 RL2
      end
      PROXY_OFS:
      begin
        w[HOST_PRIVILEGE_LEVEL_BIT] = st.host_privilege_level;
        w[HOST_PRIVILEGE_ID_LSB +: ID_W] = st.host_privilege_id;
      end
      SRC_RLD_OFS:
      begin
        w[RLD_LSB +: CNT_W] = st.first_dim_byte_count_rld; // RL8
      end
      SRC_SBASE_OFS:
      begin
        w = st.src_base; // RL10
      end
      SRC_DBASE_OFS:
      begin
        w = READ_ZERO;
      end
      DST_RLD_OFS:
      begin
        w[RLD_LSB +: CNT_W] = st.dst_first_dim_byte_count_rld; // RL8
      end
      DST_SBASE_OFS:
      begin
        w = READ_ZERO; // RL11
      end
      STATUS_OFS:
      begin
        w[STAT_BUSY_BIT] = (st.state != ST_IDLE);
        w[STAT_CMD_BIT] = st.cmd_valid;
        w[STAT_PAUSE_BIT] = st.pause;
      end
      WORK_CNT_OFS:
      begin
        w[WORK_FIRST_DIM_BYTE_COUNT_LSB +: CNT_W] = st.first_dim_byte_count;
        w[WORK_BCNT_LSB +: CNT_W] = st.bcnt;
      end
      CTRL_OFS:
      begin
        w[CTRL_PAUSE_BIT] = st.pause;
      end
      default:
      begin
        w = READ_ZERO;
      end
    endcase
    read_word = w;
  endfunction

  always_comb
  begin
    logic [CNT_W-1:0] rd_bytes;
    rd_bytes = (s.first_dim_byte_count < CHUNK_BYTES) ? s.first_dim_byte_count : CHUNK_BYTES;
    n = s;
    n.done = 1'b0;
    n.rdata = READ_ZERO;
    if (RD_EN)
    begin
      n.rdata = read_word(ADDR, s);
    end
    // Only the control word takes writes
    if (WR_EN && ADDR == CTRL_OFS) // RL13
    begin
      n.pause = WDATA[CTRL_PAUSE_BIT];
    end
    case (s.state)
      ST_IDLE:
      begin
        if (TR_VALID)
        begin
          n.host_privilege_level = TR_HOST_PRIVILEGE_LEVEL; // RL3
          n.host_privilege_id = TR_HOST_DSP ? HOST_PRIVILEGE_ID_DSP : HOST_PRIVILEGE_ID_OTHER; // RL5 RL7
          n.src_stride = TR_SRC_STRIDE;
          n.dst_stride = TR_DST_STRIDE;
          n.first_dim_byte_count_rld = TR_FIRST_DIM_BYTE_COUNT; // RL8
          n.dst_first_dim_byte_count_rld = TR_FIRST_DIM_BYTE_COUNT; // RL8
          n.first_dim_byte_count = TR_FIRST_DIM_BYTE_COUNT;
          n.bcnt = TR_BCNT;
          n.src_base = TR_SRC_ADDR; // RL10
          n.src_addr = TR_SRC_ADDR;
          n.dst_base = TR_DST_ADDR;
          n.dst_addr = TR_DST_ADDR;
          if (TR_FIRST_DIM_BYTE_COUNT != '0 && TR_BCNT != '0)
          begin
            n.state = ST_READ;
          end
          else
          begin
            n.done = 1'b1;
          end
        end
      end
      ST_READ:
      begin
        if (!s.cmd_valid)
        begin
          if (!s.pause)
          begin
            n.cmd_valid = 1'b1;
            n.cmd_write = 1'b0;
            n.cmd_addr = s.src_addr;
            n.cmd_bytes = rd_bytes;
            n.src_addr = step_base(s.src_addr, rd_bytes);
            n.first_dim_byte_count = s.first_dim_byte_count - rd_bytes; // RL12
          end
        end
        else if (CMD_READY)
        begin
          // Matching write follows the accepted read at once
          n.cmd_write = 1'b1;
          n.cmd_addr = s.dst_addr;
          n.dst_addr = step_base(s.dst_addr, s.cmd_bytes);
          n.state = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (CMD_READY)
        begin
          n.cmd_valid = 1'b0;
          n.cmd_write = 1'b0;
          n.state = ST_READ;
          if (s.first_dim_byte_count == '0)
          begin
            n.bcnt = s.bcnt - CNT_ONE;
            if (s.bcnt == CNT_ONE)
            begin
              n.state = ST_IDLE;
              n.done = 1'b1;
            end
            else
            begin
              n.src_base = step_base(s.src_base, s.src_stride); // RL10
              n.src_addr = step_base(s.src_base, s.src_stride);
              n.dst_base = step_base(s.dst_base, s.dst_stride);
              n.dst_addr = step_base(s.dst_base, s.dst_stride);
              n.first_dim_byte_count = s.first_dim_byte_count_rld; // RL9
            end
          end
        end
      end
      default:
      begin
        n.state = ST_IDLE;
        n.cmd_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign RDATA = s.rdata;
  assign TR_READY = (s.state == ST_IDLE);
  assign TR_DONE = s.done;
  assign CMD_VALID = s.cmd_valid;
  assign CMD_WRITE = s.cmd_write;
  assign CMD_ADDR = s.cmd_addr;
  assign CMD_BYTES = s.cmd_bytes;
  assign CMD_HOST_PRIVILEGE_LEVEL = s.host_privilege_level; // RL4
  assign CMD_HOST_PRIVILEGE_ID = s.host_privilege_id; // RL6

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_stride_low_read: // RL1
    assert property (RD_EN && ADDR == STRIDE_OFS
      |=> RDATA[15:0] == $past(s.src_stride))
    else $error("stride read does not show source stride");

  a_stride_upper_zero: // RL2
    assert property (RD_EN && ADDR == STRIDE_OFS
      |=> RDATA[31:16] == 16'h0000)
    else $error("destination stride half not zero");

  a_host_privilege_level_capture: // RL3
    assert property (TR_VALID && TR_READY
      |=> s.host_privilege_level == $past(TR_HOST_PRIVILEGE_LEVEL) && CMD_HOST_PRIVILEGE_LEVEL == $past(TR_HOST_PRIVILEGE_LEVEL))
    else $error("privilege level not captured");

  a_cmd_host_privilege_level_held: // RL4
    assert property (CMD_VALID && !CMD_READY
      |=> CMD_HOST_PRIVILEGE_LEVEL == $past(CMD_HOST_PRIVILEGE_LEVEL) && CMD_VALID)
    else $error("command privilege changed while pending");

  a_host_privilege_id_capture: // RL5
    assert property (TR_VALID && TR_READY
      |=> CMD_HOST_PRIVILEGE_ID == ($past(TR_HOST_DSP) ? 4'h1 : 4'h0))
    else $error("privilege id not captured");

  a_cmd_host_privilege_id_read: // RL6
    assert property (RD_EN && ADDR == PROXY_OFS
      |=> RDATA[3:0] == CMD_HOST_PRIVILEGE_ID && RDATA[8] == CMD_HOST_PRIVILEGE_LEVEL)
    else $error("proxy register and command id differ");

  a_host_privilege_id_encoding: // RL7
    assert property (CMD_VALID |-> CMD_HOST_PRIVILEGE_ID inside {4'h0, 4'h1})
    else $error("privilege id outside host encoding");

  a_reload_stable: // RL8
    assert property (s.state != ST_IDLE && $past(s.state) != ST_IDLE
      |-> $stable(s.first_dim_byte_count_rld) && s.dst_first_dim_byte_count_rld == s.first_dim_byte_count_rld)
    else $error("count reload changed during transfer");

  a_first_dim_byte_count_reload: // RL9
    assert property (s.state == ST_WRITE && CMD_READY && s.first_dim_byte_count == 16'h0000
      && s.bcnt > 16'h0001 |=> s.first_dim_byte_count == s.first_dim_byte_count_rld)
    else $error("working count not reloaded after array");

  a_src_base_cmd: // RL10
    assert property (s.state == ST_READ && !s.cmd_valid && !s.pause
      && s.first_dim_byte_count == s.first_dim_byte_count_rld |=> CMD_ADDR == s.src_base && !CMD_WRITE)
    else $error("first read of array not at source base");

  a_dst_base_zero: // RL11
    assert property (RD_EN && ADDR == DST_SBASE_OFS |=> RDATA == 32'h0)
    else $error("destination set source base not zero");

  a_first_dim_byte_count_decrement: // RL12
    assert property (s.state == ST_READ && !s.cmd_valid && !s.pause
      |=> CMD_VALID ##0 s.first_dim_byte_count == $past(s.first_dim_byte_count) - CMD_BYTES)
    else $error("working count not reduced by read size");

  a_write_ignored: // RL13
    assert property (WR_EN && ADDR != CTRL_OFS && s.state == ST_IDLE
      && !TR_VALID |=> $stable(s.src_stride) && $stable(s.host_privilege_level)
      && $stable(s.src_base) && $stable(s.first_dim_byte_count_rld))
    else $error("write changed captured transfer state");

endmodule

// ---- dtas_pkg.sv ----
package dtas_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int ID_W = 4;

  // Register word offsets (byte addresses)
  localparam logic [7:0] STRIDE_OFS = 8'h00;
  localparam logic [7:0] PROXY_OFS = 8'h04;
  localparam logic [7:0] SRC_RLD_OFS = 8'h08;
  localparam logic [7:0] SRC_SBASE_OFS = 8'h0c;
  localparam logic [7:0] SRC_DBASE_OFS = 8'h10;
  localparam logic [7:0] DST_RLD_OFS = 8'h14;
  localparam logic [7:0] DST_SBASE_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  localparam logic [7:0] WORK_CNT_OFS = 8'h20;
  localparam logic [7:0] CTRL_OFS = 8'h24;

  // Field positions
  localparam int SRC_STRIDE_LSB = 0;
  localparam int HOST_PRIVILEGE_LEVEL_BIT = 8;
  localparam int HOST_PRIVILEGE_ID_LSB = 0;
  localparam int RLD_LSB = 0;
  localparam int WORK_FIRST_DIM_BYTE_COUNT_LSB = 0;
  localparam int WORK_BCNT_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CMD_BIT = 1;
  localparam int STAT_PAUSE_BIT = 2;
  localparam int CTRL_PAUSE_BIT = 0;

  // Values
  localparam logic [ID_W-1:0] HOST_PRIVILEGE_ID_DSP = 4'h1;
  localparam logic [ID_W-1:0] HOST_PRIVILEGE_ID_OTHER = 4'h0;
  localparam logic [CNT_W-1:0] CHUNK_BYTES = 16'h0010;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dtas_phase_e;

  typedef struct packed {
    dtas_phase_e state;
    logic pause;
    logic host_privilege_level;
    logic [ID_W-1:0] host_privilege_id;
    logic [CNT_W-1:0] src_stride;
    logic [CNT_W-1:0] dst_stride;
    logic [CNT_W-1:0] first_dim_byte_count_rld;
    logic [CNT_W-1:0] dst_first_dim_byte_count_rld;
    logic [CNT_W-1:0] first_dim_byte_count;
    logic [CNT_W-1:0] bcnt;
    logic [DATA_W-1:0] src_base;
    logic [DATA_W-1:0] src_addr;
    logic [DATA_W-1:0] dst_base;
    logic [DATA_W-1:0] dst_addr;
    logic cmd_valid;
    logic cmd_write;
    logic [DATA_W-1:0] cmd_addr;
    logic [CNT_W-1:0] cmd_bytes;
    logic done;
    logic [DATA_W-1:0] rdata;
  } dtas_state_s;

endpackage

// ---- dtas_endpoint.sv ----
module dtas_endpoint
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SLOW,
  output logic CMD_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // Slow mode accepts in one cycle of four
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      cnt <= 2'h0;
      CMD_READY <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      CMD_READY <= !SLOW || (cnt == 2'h3);
    end
endmodule

// ---- dtas_active_set_tb.sv ----
module dtas_active_set_tb;
  import dtas_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic WR_EN = 1'b0;
  logic RD_EN = 1'b0;
  logic TR_VALID = 1'b0;
  logic TR_HOST_PRIVILEGE_LEVEL = 1'b0;
  logic TR_HOST_DSP = 1'b0;
  logic SLOW = 1'b0;
  logic [ADDR_W-1:0] ADDR = 8'h00;
  logic [DATA_W-1:0] WDATA = '0;
  logic [DATA_W-1:0] TR_SRC_ADDR = '0;
  logic [DATA_W-1:0] TR_DST_ADDR = '0;
  logic [CNT_W-1:0] TR_FIRST_DIM_BYTE_COUNT = '0;
  logic [CNT_W-1:0] TR_BCNT = '0;
  logic [CNT_W-1:0] TR_SRC_STRIDE = '0;
  logic [CNT_W-1:0] TR_DST_STRIDE = '0;
  logic [DATA_W-1:0] RDATA, CMD_ADDR;
  logic TR_READY, TR_DONE, CMD_VALID, CMD_READY, CMD_WRITE, CMD_HOST_PRIVILEGE_LEVEL;
  logic [CNT_W-1:0] CMD_BYTES;
  logic [ID_W-1:0] CMD_HOST_PRIVILEGE_ID;
  logic [DATA_W-1:0] rd_q[$];
  logic [53:0] cmd_q[$];
  logic rd_pend = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h1be7;
  int i;
  logic [7:0] a;

  always #20 CLK = ~CLK;

  dtas_active_set dtas_active_set_inst (.CLK, .RST_N, .ADDR, .WDATA,
    .WR_EN, .RD_EN, .RDATA, .TR_VALID, .TR_READY, .TR_SRC_ADDR,
    .TR_DST_ADDR, .TR_FIRST_DIM_BYTE_COUNT, .TR_BCNT, .TR_SRC_STRIDE, .TR_DST_STRIDE,
    .TR_HOST_PRIVILEGE_LEVEL, .TR_HOST_DSP, .TR_DONE, .CMD_VALID, .CMD_READY, .CMD_WRITE,
    .CMD_ADDR, .CMD_BYTES, .CMD_HOST_PRIVILEGE_LEVEL, .CMD_HOST_PRIVILEGE_ID);
  dtas_endpoint dtas_endpoint_inst (.CLK, .RST_N, .SLOW, .CMD_READY);

  task print_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk_rd(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error RDATA exp %h got %h", e, g);
    end
  endtask

  task chk_cmd(input logic [53:0] e, input logic [53:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error CMD exp %h got %h", e, g);
    end
  endtask

  // Results are taken at the edge, before that edge's updates land
  always @(posedge CLK)
  begin
    if (rd_pend)
      chk_rd(rd_q.size() ? rd_q.pop_front() : 'x, RDATA);
    rd_pend <= RD_EN;
    if (CMD_VALID === 1'b1 && CMD_READY === 1'b1)
      chk_cmd(cmd_q.size() ? cmd_q.pop_front() : 'x, {CMD_WRITE, CMD_ADDR,
        CMD_BYTES, CMD_HOST_PRIVILEGE_LEVEL, CMD_HOST_PRIVILEGE_ID});
  end

  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
    input logic [31:0] e);
    WR_EN <= w;
    RD_EN <= !w;
    ADDR <= ad;
    WDATA <= d;
    if (!w)
      rd_q.push_back(e);
    @(posedge CLK);
  endtask

  task idle;
    WR_EN <= 1'b0;
    RD_EN <= 1'b0;
    @(posedge CLK);
  endtask

  task wait_done(input int lim);
    int k;
    for (k = 0; k < lim; k++)
    begin
      @(posedge CLK);
      if (TR_DONE === 1'b1)
        break;
    end
    if (k == lim)
    begin
      fail_count++;
      print_verdict;
    end
  endtask

  task xfer(input logic p, input logic h, input logic [15:0] ac,
    input logic [15:0] bc, input logic sl);
    logic [31:0] s, d, sa, da;
    logic [15:0] ss, ds, r, n;
    logic [3:0] id;
    int b;
    s = $random(seed);
    d = $random(seed);
    ss = $random(seed);
    ds = $random(seed);
    id = h ? HOST_PRIVILEGE_ID_DSP : HOST_PRIVILEGE_ID_OTHER;
    for (b = 0; b < bc; b++)
    begin
      sa = s + b * ss;
      da = d + b * ds;
      r = ac;
      while (r != 0)
      begin
        n = (r > CHUNK_BYTES) ? CHUNK_BYTES : r;
        cmd_q.push_back({1'b0, sa, n, p, id});
        cmd_q.push_back({1'b1, da, n, p, id});
        sa += n;
        da += n;
        r -= n;
      end
    end
    TR_VALID <= 1'b1;
    TR_HOST_PRIVILEGE_LEVEL <= p;
    TR_HOST_DSP <= h;
    TR_SRC_ADDR <= s;
    TR_DST_ADDR <= d;
    TR_FIRST_DIM_BYTE_COUNT <= ac;
    TR_BCNT <= bc;
    TR_SRC_STRIDE <= ss;
    TR_DST_STRIDE <= ds;
    SLOW <= sl;
    @(posedge CLK);
    chk_rd(32'h1, {31'h0, TR_READY});
    TR_VALID <= 1'b0;
    if (ac == 0 || bc == 0)
      wait_done(3);
    bus(0, SRC_SBASE_OFS, 0, s);
    bus(0, PROXY_OFS, 0, {23'h0, p, 4'h0, id});
    bus(0, STRIDE_OFS, 0, {16'h0, ss});
    bus(0, SRC_RLD_OFS, 0, {16'h0, ac});
    bus(0, DST_RLD_OFS, 0, {16'h0, ac});
    bus(0, DST_SBASE_OFS, 0, READ_ZERO);
    idle;
    if (ac != 0 && bc != 0)
      wait_done(3000);
    bus(1, STRIDE_OFS, '1, 0);
    bus(1, PROXY_OFS, '1, 0);
    bus(0, STRIDE_OFS, 0, {16'h0, ss});
    bus(0, PROXY_OFS, 0, {23'h0, p, 4'h0, id});
    bus(0, WORK_CNT_OFS, 0, (ac == 0 || bc == 0) ? {bc, ac} : 32'h0);
    bus(0, STATUS_OFS, 0, 32'h0);
    idle;
  endtask

  initial
  begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    for (a = 8'h00; a < 8'h1c; a += 8'h04)
      bus(1, a, '1, 0);
    for (a = 8'h00; a < 8'h1c; a += 8'h04)
      bus(0, a, 0, READ_ZERO);
    bus(0, 8'h3c, 0, READ_ZERO);
    // Pause bit is the one writable field
    bus(1, CTRL_OFS, 32'h1, 0);
    bus(0, CTRL_OFS, 0, 32'h1);
    bus(0, STATUS_OFS, 0, 32'h4);
    bus(1, CTRL_OFS, 32'h0, 0);
    bus(0, CTRL_OFS, 0, 32'h0);
    idle;
    for (i = 0; i < 4; i++)
      xfer(i[0], i[1], 16'd17 + ($random(seed) & 16'hf), 16'h2, i[0] ^ i[1]);
    xfer(1'b1, 1'b1, 16'h0, 16'h3, 1'b0);
    idle;
    idle;
    // Every expected command must have been issued
    if (cmd_q.size() != 0 || rd_q.size() != 0)
    begin
      fail_count++;
      $display("Error queues left %0d %0d", cmd_q.size(), rd_q.size());
    end
    print_verdict;
  end
endmodule
